// file: cpu_register_file_flags.sv
/*
 * register file and condition flags of the 8-bit core, with an
 * avalon-mm slave (waitrequest) giving software access to every register except the fetch address and strobe registers.
 * assumes decoder/alu requests come from logic on core_clk.
 */
// Local design decisions: the register addresses and register access over Avalon-MM.
// Notes on behaviour
// - fetch uses instruction pointer, then advances it
// - stack pointer holds top of stack
// - two index base registers for indexed addressing
// - vector page gives upper byte, mode 2
// - refresh counts low seven bits, bit 7 kept
// - two accumulators, two flag registers, active used
// - swap exchanges primary and shadow accumulator/flags
// - two banks of six bytes, pairable
// - bank swap exchanges all six registers
// - carry from msb on add, sub, shifts
// - zero on zero arithmetic or logical result
// - zero also from bit test and shifts
// - logical address expanded to 20-bit physical
// - sign set when result negative
// - parity after logic, overflow after arithmetic
// - half carry from lower four bits
// - subtract flag steers decimal adjust
module cpu_register_file_flags (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire rf_pkg::core_req_t core_req,
  input wire logic [7:0] irq_vector_lo,
  output logic [15:0] logical_address_out,
  output logic [19:0] phys_address_out,
  output logic fetch_strobe,
  output logic [15:0] mode2_target,
  output logic [7:0] acc_out,
  output logic [7:0] flags_out,
  output rf_pkg::gp_bank_t gp_bank_out
);
  import rf_pkg::*;

  logic [1:0] rst_sync_ff;
  logic rst_n;
  state_t st_ff;
  state_t nxt_st;
  logic bus_take;
  logic bus_wr;
  logic [16:0] alu_res;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // {write_acc, result, flags}
  function automatic logic [16:0] alu_calc(input alu_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [2:0] bsel,
      input logic [7:0] fin);
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] corr;
    logic wr;
    logic cin;
    r = a;
    f = fin;
    wr = 1'b1;
    s = 9'h000;
    hs = 5'h00;
    corr = 8'h00;
    cin = fin[FLAG_C] & (op == OP_ADC || op == OP_SBC);
    case (op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r = s[7:0];
        f[FLAG_C] = s[8];
        f[FLAG_H] = hs[4];
        f[FLAG_PV] = (a[7] == b[7]) && (r[7] != a[7]);
        f[FLAG_N] = 1'b0;
      end
      OP_SUB, OP_SBC: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        r = s[7:0];
        f[FLAG_C] = s[8];
        f[FLAG_H] = hs[4];
        f[FLAG_PV] = (a[7] != b[7]) && (r[7] != a[7]);
        f[FLAG_N] = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR: begin
        r = (op == OP_AND) ? (a & b) : (op == OP_OR) ? (a | b) : (a ^ b);
        f[FLAG_C] = 1'b0;
        f[FLAG_H] = (op == OP_AND);
        f[FLAG_PV] = ~^r;
        f[FLAG_N] = 1'b0;
      end
      OP_INC: begin
        r = a + 8'h01;
        f[FLAG_H] = (a[3:0] == 4'hF);
        f[FLAG_PV] = (a == 8'h7F);
        f[FLAG_N] = 1'b0;
      end
      OP_DEC: begin
        r = a - 8'h01;
        f[FLAG_H] = (a[3:0] == 4'h0);
        f[FLAG_PV] = (a == 8'h80);
        f[FLAG_N] = 1'b1;
      end
      OP_RLC, OP_SLA: begin
        r = {a[6:0], (op == OP_RLC) ? a[7] : 1'b0};
        f[FLAG_C] = a[7];
        f[FLAG_H] = 1'b0;
        f[FLAG_PV] = ~^r;
        f[FLAG_N] = 1'b0;
      end
      OP_DECIMAL_ADJUST: begin
        if (fin[FLAG_H] || a[3:0] > 4'h9) begin
          corr[3:0] = 4'h6;
        end
        if (fin[FLAG_C] || a > 8'h99) begin
          corr[7:4] = 4'h6;
        end
        // direction of correction follows the previous operation
        r = fin[FLAG_N] ? (a - corr) : (a + corr);
        f[FLAG_H] = fin[FLAG_N] ? (fin[FLAG_H] && a[3:0] < 4'h6)
                                : (a[3:0] > 4'h9);
        f[FLAG_C] = fin[FLAG_C] | (a > 8'h99);
        f[FLAG_PV] = ~^r;
      end
      OP_BIT: begin
        wr = 1'b0;
        f[FLAG_Z] = ~b[bsel];
        f[FLAG_PV] = ~b[bsel];
        f[FLAG_S] = 1'b0;
        f[FLAG_H] = 1'b1;
        f[FLAG_N] = 1'b0;
      end
      default: begin
        wr = 1'b0;
      end
    endcase
    if (op != OP_BIT) begin
      f[FLAG_S] = r[7];
      f[FLAG_Z] = (r == 8'h00);
    end
    return {wr, r, f};
  endfunction : alu_calc

  assign bus_take = (read || write) && st_ff.waitreq;
  assign bus_wr = write && !st_ff.waitreq;
  assign alu_res = alu_calc(core_req.alu_op, st_ff.acc, core_req.alu_arg,
                            core_req.bit_sel, st_ff.flags);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fetch_strobe = 1'b0;
    if (core_req.fetch) begin
      nxt_st.logical_address = st_ff.next_instr_pointer;
      nxt_st.next_instr_pointer = st_ff.next_instr_pointer + 16'h0001;
      nxt_st.fetch_strobe = 1'b1;
      nxt_st.refresh = {st_ff.refresh[7],
                        st_ff.refresh[6:0] + 7'h01};
      nxt_st.phys_address = {4'h0, st_ff.next_instr_pointer}
                          + {st_ff.mmu_base, 12'h000};
    end
    if (core_req.ptr_wr) begin
      unique case (core_req.ptr_sel)
        PTR_NEXT: nxt_st.next_instr_pointer = core_req.ptr_data;
        PTR_STACK: nxt_st.stack_top_pointer = core_req.ptr_data;
        PTR_IDX1: nxt_st.first_index_base = core_req.ptr_data;
        PTR_IDX2: nxt_st.second_index_base = core_req.ptr_data;
      endcase
    end
    nxt_st.mode2_target = {st_ff.vec_page, irq_vector_lo};
    if (core_req.swap_acc_flags_op) begin
      nxt_st.acc = st_ff.acc_sh;
      nxt_st.flags = st_ff.flags_sh;
      nxt_st.acc_sh = st_ff.acc;
      nxt_st.flags_sh = st_ff.flags;
    end else if (core_req.alu_en) begin
      nxt_st.flags = alu_res[7:0];
      if (alu_res[16]) begin
        nxt_st.acc = alu_res[15:8];
      end
    end
    if (core_req.swap_general_bank_op) begin
      nxt_st.gp_pri = st_ff.gp_sh;
      nxt_st.gp_sh = st_ff.gp_pri;
    end else if (core_req.pair_wr && core_req.pair_sel <= PAIR_HL) begin
      nxt_st.gp_pri[16 * (2 - int'(core_req.pair_sel)) +: 16] =
        core_req.pair_data;
    end else if (core_req.gp_wr && core_req.gp_sel <= GP_L) begin
      nxt_st.gp_pri[8 * (5 - int'(core_req.gp_sel)) +: 8] =
        core_req.gp_data;
    end
    // bus slave: waitrequest drops for one cycle per taken request
    nxt_st.waitreq = !bus_take;
    if (bus_take && read) begin
      case (address)
        OFF_NEXT_PTR: nxt_st.rdata = {16'h0000, st_ff.next_instr_pointer};
        OFF_STACK_PTR: nxt_st.rdata = {16'h0000, st_ff.stack_top_pointer};
        OFF_IDX1: nxt_st.rdata = {16'h0000, st_ff.first_index_base};
        OFF_IDX2: nxt_st.rdata = {16'h0000, st_ff.second_index_base};
        OFF_VEC_PAGE: nxt_st.rdata = {24'h00_0000, st_ff.vec_page};
        OFF_REFRESH: nxt_st.rdata = {24'h00_0000, st_ff.refresh};
        OFF_AF: nxt_st.rdata = {16'h0000, st_ff.acc, st_ff.flags};
        OFF_AF_SH: nxt_st.rdata = {16'h0000, st_ff.acc_sh, st_ff.flags_sh};
        OFF_BC: nxt_st.rdata = {16'h0000, st_ff.gp_pri.b, st_ff.gp_pri.c};
        OFF_DE: nxt_st.rdata = {16'h0000, st_ff.gp_pri.d, st_ff.gp_pri.e};
        OFF_HL: nxt_st.rdata = {16'h0000, st_ff.gp_pri.h, st_ff.gp_pri.l};
        OFF_BC_SH: nxt_st.rdata = {16'h0000, st_ff.gp_sh.b, st_ff.gp_sh.c};
        OFF_DE_SH: nxt_st.rdata = {16'h0000, st_ff.gp_sh.d, st_ff.gp_sh.e};
        OFF_HL_SH: nxt_st.rdata = {16'h0000, st_ff.gp_sh.h, st_ff.gp_sh.l};
        OFF_MMU_BASE: nxt_st.rdata = {24'h00_0000, st_ff.mmu_base};
        OFF_MODE2_TGT: nxt_st.rdata = {16'h0000, st_ff.mode2_target};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // software write lands last and wins over core updates
    if (bus_wr) begin
      case (address)
        OFF_NEXT_PTR: nxt_st.next_instr_pointer = writedata[15:0];
        OFF_STACK_PTR: nxt_st.stack_top_pointer = writedata[15:0];
        OFF_IDX1: nxt_st.first_index_base = writedata[15:0];
        OFF_IDX2: nxt_st.second_index_base = writedata[15:0];
        OFF_VEC_PAGE: nxt_st.vec_page = writedata[7:0];
        OFF_REFRESH: nxt_st.refresh = writedata[7:0];
        OFF_AF: {nxt_st.acc, nxt_st.flags} = writedata[15:0];
        OFF_AF_SH: {nxt_st.acc_sh, nxt_st.flags_sh} = writedata[15:0];
        OFF_BC: {nxt_st.gp_pri.b, nxt_st.gp_pri.c} = writedata[15:0];
        OFF_DE: {nxt_st.gp_pri.d, nxt_st.gp_pri.e} = writedata[15:0];
        OFF_HL: {nxt_st.gp_pri.h, nxt_st.gp_pri.l} = writedata[15:0];
        OFF_BC_SH: {nxt_st.gp_sh.b, nxt_st.gp_sh.c} = writedata[15:0];
        OFF_DE_SH: {nxt_st.gp_sh.d, nxt_st.gp_sh.e} = writedata[15:0];
        OFF_HL_SH: {nxt_st.gp_sh.h, nxt_st.gp_sh.l} = writedata[15:0];
        OFF_MMU_BASE: nxt_st.mmu_base = writedata[7:0];
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{next_instr_pointer: RST_WORD, stack_top_pointer: RST_WORD,
                 first_index_base: RST_WORD, second_index_base: RST_WORD,
                 vec_page: RST_BYTE, refresh: RST_BYTE, acc: RST_BYTE,
                 flags: RST_FLAGS, acc_sh: RST_BYTE, flags_sh: RST_FLAGS,
                 gp_pri: '0, gp_sh: '0, mmu_base: RST_MMU_BASE,
                 logical_address: RST_WORD, phys_address: 20'h0_0000,
                 fetch_strobe: 1'b0, mode2_target: RST_WORD,
                 waitreq: 1'b1, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.waitreq;
  assign logical_address_out = st_ff.logical_address;
  assign phys_address_out = st_ff.phys_address;
  assign fetch_strobe = st_ff.fetch_strobe;
  assign mode2_target = st_ff.mode2_target;
  assign acc_out = st_ff.acc;
  assign flags_out = st_ff.flags;
  assign gp_bank_out = st_ff.gp_pri;

  // helpers for the checks below
  logic af_quiet;
  logic gp_quiet;
  assign af_quiet = !(bus_wr && (address == OFF_AF || address == OFF_AF_SH))
                  && !core_req.swap_acc_flags_op;
  assign gp_quiet = !(bus_wr && address >= OFF_BC && address <= OFF_HL_SH);

  property p_fetch_addr;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.fetch |=> fetch_strobe &&
      logical_address_out == $past(st_ff.next_instr_pointer);
  endproperty
  a_fetch_addr: assert property (p_fetch_addr)
    else $error("fetch did not use the instruction pointer");

  property p_ptr_advance;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.fetch && !core_req.ptr_wr &&
      !(bus_wr && address == OFF_NEXT_PTR) |=>
      st_ff.next_instr_pointer == 16'($past(st_ff.next_instr_pointer) + 1);
  endproperty
  a_ptr_advance: assert property (p_ptr_advance)
    else $error("instruction pointer did not advance");

  property p_stack_hold;
    @(posedge core_clk) disable iff (!rst_n)
    !core_req.ptr_wr && !(bus_wr && address == OFF_STACK_PTR) |=>
      $stable(st_ff.stack_top_pointer);
  endproperty
  a_stack_hold: assert property (p_stack_hold)
    else $error("stack pointer changed without a load");

  property p_idx_load;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.ptr_wr && core_req.ptr_sel == PTR_IDX2 && !bus_wr |=>
      st_ff.second_index_base == $past(core_req.ptr_data);
  endproperty
  a_idx_load: assert property (p_idx_load)
    else $error("index base load lost");

  property p_mode2;
    @(posedge core_clk) disable iff (!rst_n)
    !(bus_wr && address == OFF_VEC_PAGE) ##1 1'b1 |=>
      mode2_target[15:8] == $past(st_ff.vec_page, 2);
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("vector target upper byte wrong");

  property p_refresh;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.fetch && !(bus_wr && address == OFF_REFRESH) |=>
      st_ff.refresh[7] == $past(st_ff.refresh[7]) &&
      st_ff.refresh[6:0] == 7'($past(st_ff.refresh[6:0]) + 1);
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh counter step wrong");

  property p_acc_add;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op == OP_ADD && af_quiet |=>
      acc_out == 8'($past(st_ff.acc) + $past(core_req.alu_arg)) &&
      flags_out[FLAG_C] == ({1'b0, $past(st_ff.acc)} +
        {1'b0, $past(core_req.alu_arg)} > 9'h0FF) &&
      flags_out[FLAG_S] == acc_out[7] && !flags_out[FLAG_N];
  endproperty
  a_acc_add: assert property (p_acc_add)
    else $error("add result or carry wrong");

  property p_swap_af;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.swap_acc_flags_op && !bus_wr |=>
      acc_out == $past(st_ff.acc_sh) && st_ff.acc_sh == $past(st_ff.acc)
      && flags_out == $past(st_ff.flags_sh);
  endproperty
  a_swap_af: assert property (p_swap_af)
    else $error("accumulator swap wrong");

  property p_swap_gp;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.swap_general_bank_op && gp_quiet |=>
      st_ff.gp_pri == $past(st_ff.gp_sh) && st_ff.gp_sh == $past(st_ff.gp_pri);
  endproperty
  a_swap_gp: assert property (p_swap_gp)
    else $error("bank swap wrong");

  property p_pair_hl;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.pair_wr && core_req.pair_sel == PAIR_HL &&
      !core_req.swap_general_bank_op && gp_quiet |=>
      {gp_bank_out.h, gp_bank_out.l} == $past(core_req.pair_data);
  endproperty
  a_pair_hl: assert property (p_pair_hl)
    else $error("pair write wrong");

  property p_zero;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op != OP_BIT && af_quiet |=>
      flags_out[FLAG_Z] == (acc_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_bit_zero;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op == OP_BIT && af_quiet |=>
      flags_out[FLAG_Z] == !$past(core_req.alu_arg[core_req.bit_sel]) &&
      $stable(acc_out);
  endproperty
  a_bit_zero: assert property (p_bit_zero)
    else $error("bit test zero wrong");

  property p_phys;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.fetch |=> phys_address_out ==
      20'({4'h0, $past(st_ff.next_instr_pointer)} +
          {$past(st_ff.mmu_base), 12'h000});
  endproperty
  a_phys: assert property (p_phys)
    else $error("physical address wrong");

  property p_overflow_inc;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op == OP_INC && af_quiet |=>
      flags_out[FLAG_PV] == ($past(st_ff.acc) == 8'h7F) &&
      flags_out[FLAG_H] == ($past(st_ff.acc[3:0]) == 4'hF);
  endproperty
  a_overflow_inc: assert property (p_overflow_inc)
    else $error("increment overflow or half carry wrong");

  property p_sub_flag;
    @(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op == OP_SUB && af_quiet |=>
      flags_out[FLAG_N] && flags_out[FLAG_C] ==
        ($past(st_ff.acc) < $past(core_req.alu_arg));
  endproperty
  a_sub_flag: assert property (p_sub_flag)
    else $error("subtract flag or borrow wrong");

  property p_bus_answer;
    @(posedge core_clk) disable iff (!rst_n)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  c_fetch: cover property (@(posedge core_clk) disable iff (!rst_n)
    core_req.fetch ##1 core_req.fetch);
  c_swap_af: cover property (@(posedge core_clk) disable iff (!rst_n)
    core_req.swap_acc_flags_op ##1 core_req.swap_acc_flags_op);
  c_swap_gp: cover property (@(posedge core_clk) disable iff (!rst_n)
    core_req.swap_general_bank_op);
  c_adjust: cover property (@(posedge core_clk) disable iff (!rst_n)
    core_req.alu_en && core_req.alu_op == OP_DECIMAL_ADJUST);

endmodule : cpu_register_file_flags

// file: rf_pkg.sv
/*
 * constants, field layouts and carrier types shared by the register file
 * and condition-flag block of the 8-bit core.
 * assumes a single core clock; all users import the whole package.
 */
package rf_pkg;

  // flag register bit positions; bits 5 and 3 carry no meaning
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;

  // register map, byte addresses of aligned 32-bit words
  localparam logic [7:0] OFF_NEXT_PTR = 8'h00;
  localparam logic [7:0] OFF_STACK_PTR = 8'h04;
  localparam logic [7:0] OFF_IDX1 = 8'h08;
  localparam logic [7:0] OFF_IDX2 = 8'h0C;
  localparam logic [7:0] OFF_VEC_PAGE = 8'h10;
  localparam logic [7:0] OFF_REFRESH = 8'h14;
  localparam logic [7:0] OFF_AF = 8'h18;
  localparam logic [7:0] OFF_AF_SH = 8'h1C;
  localparam logic [7:0] OFF_BC = 8'h20;
  localparam logic [7:0] OFF_DE = 8'h24;
  localparam logic [7:0] OFF_HL = 8'h28;
  localparam logic [7:0] OFF_BC_SH = 8'h2C;
  localparam logic [7:0] OFF_DE_SH = 8'h30;
  localparam logic [7:0] OFF_HL_SH = 8'h34;
  localparam logic [7:0] OFF_MMU_BASE = 8'h38;
  localparam logic [7:0] OFF_MODE2_TGT = 8'h3C;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MMU_BASE = 8'h00;

  // general register selects within a bank
  localparam logic [2:0] GP_B = 3'h0;
  localparam logic [2:0] GP_L = 3'h5;
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_HL = 2'h2;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR,
    OP_INC, OP_DEC, OP_RLC, OP_SLA, OP_DECIMAL_ADJUST, OP_BIT
  } alu_op_t;

  typedef enum logic [1:0] {
    PTR_NEXT, PTR_STACK, PTR_IDX1, PTR_IDX2
  } ptr_sel_t;

  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] h;
    logic [7:0] l;
  } gp_bank_t;

  typedef struct packed {
    logic fetch;
    logic swap_acc_flags_op;
    logic swap_general_bank_op;
    logic alu_en;
    alu_op_t alu_op;
    logic [7:0] alu_arg;
    logic [2:0] bit_sel;
    logic gp_wr;
    logic [2:0] gp_sel;
    logic [7:0] gp_data;
    logic pair_wr;
    logic [1:0] pair_sel;
    logic [15:0] pair_data;
    logic ptr_wr;
    ptr_sel_t ptr_sel;
    logic [15:0] ptr_data;
  } core_req_t;

  typedef struct packed {
    logic [15:0] next_instr_pointer;
    logic [15:0] stack_top_pointer;
    logic [15:0] first_index_base;
    logic [15:0] second_index_base;
    logic [7:0] vec_page;
    logic [7:0] refresh;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] acc_sh;
    logic [7:0] flags_sh;
    gp_bank_t gp_pri;
    gp_bank_t gp_sh;
    logic [7:0] mmu_base;
    logic [15:0] logical_address;
    logic [19:0] phys_address;
    logic fetch_strobe;
    logic [15:0] mode2_target;
    logic waitreq;
    logic [31:0] rdata;
  } state_t;

endpackage : rf_pkg

// file: core_req_model.sv
/*
 * stand-in for the decoder/alu side that issues core requests.
 * assumes the bench calls its task from the core clock domain.
 */
module core_req_model (
  input wire logic core_clk,
  output rf_pkg::core_req_t core_req
);
  import rf_pkg::*;

  initial core_req = '0;

  // one request held for exactly one cycle, launched after a rising edge
  task automatic issue(input core_req_t r);
    @(posedge core_clk);
    core_req <= r;
    @(posedge core_clk);
    core_req <= '0;
  endtask : issue
endmodule : core_req_model

// file: cpu_register_file_flags_tb_top.sv
/*
 * self-checking bench for the register file and flags block.
 * assumes the design answers each bus access one cycle after taking it.
 */
module cpu_register_file_flags_tb_top;
  import rf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk;
  logic resetn;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  core_req_t core_req;
  logic [7:0] irq_vector_lo;
  logic [15:0] logical_address_out;
  logic [19:0] phys_address_out;
  logic fetch_strobe;
  logic [15:0] mode2_target;
  logic [7:0] acc_out;
  logic [7:0] flags_out;
  gp_bank_t gp_bank_out;
  int bad_count = 0;
  int check_count = 0;

  cpu_register_file_flags u_dut (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .core_req(core_req),
    .irq_vector_lo(irq_vector_lo),
    .logical_address_out(logical_address_out),
    .phys_address_out(phys_address_out), .fetch_strobe(fetch_strobe),
    .mode2_target(mode2_target), .acc_out(acc_out), .flags_out(flags_out),
    .gp_bank_out(gp_bank_out));

  core_req_model m (.core_clk(core_clk), .core_req(core_req));

  task automatic test_done;
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %0s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // holds the request until waitrequest is seen low, then releases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    q = readdata;
    @(posedge core_clk);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(n, q, e);
  endtask : rd

  task automatic t_fetch;
    core_req_t r;
    rd(OFF_NEXT_PTR, "ptr_rst", 32'h0000_0000);
    rd(8'h40, "unmapped", 32'h0000_0000);
    wr(OFF_NEXT_PTR, 32'h0000_1234);
    wr(OFF_MMU_BASE, 32'h0000_0005);
    wr(OFF_REFRESH, 32'h0000_00FF);
    r = '0;
    r.fetch = 1'b1;
    m.issue(r);
    @(negedge core_clk);
    chk("strobe", fetch_strobe, 1'b1);
    chk("laddr", logical_address_out, 16'h1234);
    chk("paddr", phys_address_out, 20'h0_6234);
    rd(OFF_NEXT_PTR, "ptr", 32'h0000_1235);
    rd(OFF_REFRESH, "refresh", 32'h0000_0080);
  endtask : t_fetch

  task automatic t_alu;
    core_req_t r;
    logic [7:0] a [6] = '{8'h7F, 8'h80, 8'hFF, 8'hF0, 8'h81, 8'h00};
    alu_op_t op [6] = '{OP_ADD, OP_SUB, OP_ADD, OP_XOR, OP_SLA, OP_BIT};
    logic [7:0] g [6] = '{8'h01, 8'h80, 8'h01, 8'h0F, 8'h00, 8'h00};
    logic [7:0] ea [6] = '{8'h80, 8'h00, 8'h00, 8'hFF, 8'h02, 8'h00};
    logic [7:0] ef [6] = '{8'h94, 8'h42, 8'h51, 8'h84, 8'h01, 8'h54};
    for (int i = 0; i < 6; i++) begin
      wr(OFF_AF, {16'h0000, a[i], 8'h00});
      r = '0;
      r.alu_en = 1'b1;
      r.alu_op = op[i];
      r.alu_arg = g[i];
      r.bit_sel = 3'h3;
      m.issue(r);
      @(negedge core_clk);
      chk("acc", acc_out, ea[i]);
      chk("flags", flags_out, ef[i]);
    end
  endtask : t_alu

  task automatic t_swap;
    core_req_t r;
    wr(OFF_AF, 32'h0000_1122);
    wr(OFF_AF_SH, 32'h0000_3344);
    r = '0;
    r.swap_acc_flags_op = 1'b1;
    m.issue(r);
    rd(OFF_AF, "af", 32'h0000_3344);
    rd(OFF_AF_SH, "af_sh", 32'h0000_1122);
    r = '0;
    r.pair_wr = 1'b1;
    r.pair_sel = PAIR_BC;
    r.pair_data = 16'hA1B2;
    m.issue(r);
    r = '0;
    r.gp_wr = 1'b1;
    r.gp_sel = GP_L;
    r.gp_data = 8'h5C;
    m.issue(r);
    @(negedge core_clk);
    chk("bank", gp_bank_out, 48'hA1B2_0000_005C);
    r = '0;
    r.swap_general_bank_op = 1'b1;
    m.issue(r);
    @(negedge core_clk);
    chk("bank_sw", gp_bank_out, 48'h0000_0000_0000);
    rd(OFF_BC_SH, "bc_sh", 32'h0000_A1B2);
    rd(OFF_HL_SH, "hl_sh", 32'h0000_005C);
  endtask : t_swap

  task automatic t_ptr;
    core_req_t r;
    for (int i = 1; i < 4; i++) begin
      r = '0;
      r.ptr_wr = 1'b1;
      r.ptr_sel = ptr_sel_t'(i);
      r.ptr_data = 16'hBEE0 + 16'(i);
      m.issue(r);
      rd(8'(4 * i), "ptr_n", {16'h0000, 16'hBEE0 + 16'(i)});
    end
    wr(OFF_VEC_PAGE, 32'h0000_003A);
    irq_vector_lo <= 8'h7C;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("mode2", mode2_target, 16'h3A7C);
    wr(OFF_MODE2_TGT, 32'h0000_FFFF);
    rd(OFF_MODE2_TGT, "mode2_ro", 32'h0000_3A7C);
  endtask : t_ptr

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    test_done;
  end

  initial begin
    resetn = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    irq_vector_lo = 8'h00;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_fetch;
    t_alu;
    t_swap;
    t_ptr;
    test_done;
  end
endmodule : cpu_register_file_flags_tb_top
